// file: sdb_sram_port.sv
// command and data port of a separate-i/o ddr sram with four-beat bursts
// assumes k, k-bar and all controller inputs are synchronous to CLK_IN
`timescale 1ns/1ps
module sdb_sram_port #(
  parameter int ADDR_W = sdb_pkg::ADDR_W,
  parameter int LOCK_KCYC = sdb_pkg::LOCK_KCYC,
  parameter int CLK_STOP_CYC = sdb_pkg::CLK_STOP_CYC
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_IN,
  // input clocks
  input wire logic K_IN,
  input wire logic K_BAR_IN,
  // command
  input wire logic [ADDR_W-1:0] SYNC_ADDR_IN,
  input wire logic READ_SEL_N_IN,
  input wire logic WRITE_SEL_N_IN,
  // write data
  input wire logic [sdb_pkg::DATA_W-1:0] WRITE_DATA_IN,
  input wire logic [sdb_pkg::LANES-1:0] BYTE_WRITE_MASK_N_IN,
  // dll control
  input wire logic DLL_OFF_N_IN,
  // read data
  output logic [sdb_pkg::DATA_W-1:0] READ_DATA_OUT,
  output logic READ_DATA_OE_OUT,
  output logic OUT_DATA_VALID_OUT,
  output logic ECHO_CLK_OUT,
  output logic ECHO_CLK_N_OUT,
  // dll status
  output logic DLL_LOCKED_OUT
);
  localparam int MAW = ADDR_W + sdb_pkg::BEAT_W;

  initial begin
    if (ADDR_W < 1 || LOCK_KCYC < 1 || LOCK_KCYC >= (1 << sdb_pkg::LOCK_W) ||
        CLK_STOP_CYC < 1 || CLK_STOP_CYC >= (1 << sdb_pkg::IDLE_W) - 1) begin
      $error("sdb_sram_port: parameter out of range");
    end
  end

  // clock edges
  logic k_rise;
  logic kb_rise;
  logic k_change;

  sdb_edge_det u_k_edge (
    .clk_in(CLK_IN),
    .rst_in(RESET_IN),
    .level_in(K_IN),
    .rise_out(k_rise),
    .change_out(k_change)
  );

  sdb_edge_det u_kb_edge (
    .clk_in(CLK_IN),
    .rst_in(RESET_IN),
    .level_in(K_BAR_IN),
    .rise_out(kb_rise),
    .change_out()
  );

  // command state
  logic last_rd_q;
  logic last_wr_q;
  logic rd_cmd_q;
  logic rd_wait_q;
  logic [ADDR_W-1:0] rd_cmd_addr_q;
  logic rd_act_q;
  logic [sdb_pkg::BEAT_W-1:0] rd_beat_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic wr_cmd_q;
  logic [ADDR_W-1:0] wr_cmd_addr_q;
  logic wr_act_q;
  logic [sdb_pkg::BEAT_W-1:0] wr_beat_q;
  logic [ADDR_W-1:0] wr_addr_q;

  // command decode
  wire deselect = READ_SEL_N_IN & WRITE_SEL_N_IN;
  wire rd_load = k_rise & ~READ_SEL_N_IN & ~last_rd_q;
  wire wr_load = k_rise & READ_SEL_N_IN & ~WRITE_SEL_N_IN & ~last_wr_q;

  // read beat selection
  wire rd_start = k_rise & rd_cmd_q & rd_wait_q;
  wire [sdb_pkg::BEAT_W-1:0] rd_next = rd_beat_q + 2'h1;
  wire rd_next_edge = rd_next[0] ? kb_rise : k_rise;
  wire rd_step = rd_act_q & (rd_beat_q != sdb_pkg::BEAT_LAST) & rd_next_edge;
  wire rd_emit = rd_start | rd_step;
  wire [sdb_pkg::BEAT_W-1:0] rd_sel_beat = rd_start ? sdb_pkg::BEAT_FIRST : rd_next;
  wire [ADDR_W-1:0] rd_sel_addr = rd_start ? rd_cmd_addr_q : rd_addr_q;

  // write beat selection
  wire wr_start = k_rise & wr_cmd_q;
  wire [sdb_pkg::BEAT_W-1:0] wr_next = wr_beat_q + 2'h1;
  wire wr_next_edge = wr_next[0] ? kb_rise : k_rise;
  wire wr_step = wr_act_q & (wr_beat_q != sdb_pkg::BEAT_LAST) & wr_next_edge;
  wire wr_emit = wr_start | wr_step;
  wire [sdb_pkg::BEAT_W-1:0] wr_sel_beat = wr_start ? sdb_pkg::BEAT_FIRST : wr_next;
  wire [ADDR_W-1:0] wr_sel_addr = wr_start ? wr_cmd_addr_q : wr_addr_q;

  // command history on each k rise
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      last_rd_q <= 1'b0;
      last_wr_q <= 1'b0;
    end else if (k_rise) begin
      last_rd_q <= rd_load;
      last_wr_q <= wr_load;
    end
  end

  // read command wait and burst
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rd_cmd_q <= 1'b0;
      rd_wait_q <= 1'b0;
      rd_cmd_addr_q <= '0;
      rd_act_q <= 1'b0;
      rd_beat_q <= sdb_pkg::BEAT_FIRST;
      rd_addr_q <= '0;
    end else begin
      if (rd_load) begin
        rd_cmd_q <= 1'b1;
        rd_wait_q <= 1'b0;
        rd_cmd_addr_q <= SYNC_ADDR_IN;
      end else if (rd_start) begin
        rd_cmd_q <= 1'b0;
      end else if (k_rise && rd_cmd_q) begin
        rd_wait_q <= 1'b1;
      end
      if (rd_emit) begin
        rd_act_q <= (rd_sel_beat != sdb_pkg::BEAT_LAST);
        rd_beat_q <= rd_sel_beat;
        rd_addr_q <= rd_sel_addr;
      end
    end
  end

  // write command wait and burst
  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      wr_cmd_q <= 1'b0;
      wr_cmd_addr_q <= '0;
      wr_act_q <= 1'b0;
      wr_beat_q <= sdb_pkg::BEAT_FIRST;
      wr_addr_q <= '0;
    end else begin
      if (wr_load) begin
        wr_cmd_q <= 1'b1;
        wr_cmd_addr_q <= SYNC_ADDR_IN;
      end else if (wr_start) begin
        wr_cmd_q <= 1'b0;
      end
      if (wr_emit) begin
        wr_act_q <= (wr_sel_beat != sdb_pkg::BEAT_LAST);
        wr_beat_q <= wr_sel_beat;
        wr_addr_q <= wr_sel_addr;
      end
    end
  end

  // storage, four beats per address
  logic [sdb_pkg::DATA_W-1:0] rd_word;

  sdb_byte_ram #(
    .AW(MAW),
    .LANE_W(sdb_pkg::LANE_W),
    .LANES(sdb_pkg::LANES)
  ) u_ram (
    .clk_in(CLK_IN),
    .we_in(wr_emit),
    .waddr_in({wr_sel_addr, wr_sel_beat}),
    .wdata_in(WRITE_DATA_IN),
    .wmask_n_in(BYTE_WRITE_MASK_N_IN),
    .raddr_in({rd_sel_addr, rd_sel_beat}),
    .rdata_out(rd_word)
  );

  // read output stage
  logic [sdb_pkg::DATA_W-1:0] rdata_q;
  logic valid_q;
  logic echo_q;
  logic echo_n_q;

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      rdata_q <= sdb_pkg::DATA_IDLE;
      valid_q <= 1'b0;
      echo_q <= 1'b0;
      echo_n_q <= 1'b0;
    end else begin
      echo_q <= K_IN;
      echo_n_q <= K_BAR_IN;
      if (rd_emit) begin
        rdata_q <= rd_word;
        valid_q <= 1'b1;
      end else if (k_rise || kb_rise) begin
        rdata_q <= sdb_pkg::DATA_IDLE;
        valid_q <= 1'b0;
      end
    end
  end

  assign READ_DATA_OUT = rdata_q;
  assign READ_DATA_OE_OUT = valid_q;
  assign OUT_DATA_VALID_OUT = valid_q;
  assign ECHO_CLK_OUT = echo_q;
  assign ECHO_CLK_N_OUT = echo_n_q;

  // dll reset and lock tracking
  logic [sdb_pkg::IDLE_W-1:0] idle_q;
  logic [sdb_pkg::LOCK_W-1:0] lock_q;
  logic locked_q;
  wire clk_stopped = (idle_q >= sdb_pkg::IDLE_W'(CLK_STOP_CYC));
  wire dll_reset = ~DLL_OFF_N_IN | clk_stopped;
  wire lock_done = (lock_q >= sdb_pkg::LOCK_W'(LOCK_KCYC));

  always_ff @(posedge CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      idle_q <= '0;
      lock_q <= sdb_pkg::LOCK_RST;
      locked_q <= 1'b0;
    end else begin
      if (k_change) begin
        idle_q <= '0;
      end else if (!clk_stopped) begin
        idle_q <= idle_q + 1'b1;
      end
      if (dll_reset) begin
        lock_q <= sdb_pkg::LOCK_RST;
      end else if (k_rise && !lock_done) begin
        lock_q <= lock_q + 1'b1;
      end
      locked_q <= ~dll_reset & lock_done;
    end
  end

  assign DLL_LOCKED_OUT = locked_q;

  // checks
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  deselect_idle_a: assert property ((k_rise && deselect) |=>
    (!rd_cmd_q || $past(rd_cmd_q)) && (!wr_cmd_q || $past(wr_cmd_q)))
    else $error("deselect started an operation");
  read_start_a: assert property ((k_rise && !READ_SEL_N_IN && !last_rd_q) |=>
    rd_cmd_q && !rd_wait_q && rd_cmd_addr_q == $past(SYNC_ADDR_IN))
    else $error("read command not loaded");
  read_spacing_a: assert property (rd_load |-> ##2 !rd_load)
    else $error("reads loaded back to back");
  write_start_a: assert property ((k_rise && READ_SEL_N_IN && !WRITE_SEL_N_IN && !last_wr_q)
    |=> wr_cmd_q && wr_cmd_addr_q == $past(SYNC_ADDR_IN))
    else $error("write command not loaded");
  write_block_a: assert property (k_rise && !READ_SEL_N_IN |-> !wr_load)
    else $error("write loaded with read select low");
  write_spacing_a: assert property (wr_load |-> ##2 !wr_load)
    else $error("writes loaded back to back");
  write_edge_a: assert property (wr_emit |-> k_rise || kb_rise)
    else $error("write beat off a clock edge");
  write_order_a: assert property (wr_start |=> wr_act_q && wr_beat_q == 2'h0)
    else $error("write burst did not begin at beat zero");
  read_latency_a: assert property (rd_start |=> OUT_DATA_VALID_OUT && READ_DATA_OE_OUT)
    else $error("read beat not driven");
  read_idle_a: assert property (!OUT_DATA_VALID_OUT |->
    !READ_DATA_OE_OUT && READ_DATA_OUT == sdb_pkg::DATA_IDLE)
    else $error("output active outside read beat");
  dll_off_a: assert property (!DLL_OFF_N_IN |=> !DLL_LOCKED_OUT)
    else $error("locked while dll is off");
  dll_stop_a: assert property (clk_stopped |=> lock_q == sdb_pkg::LOCK_RST)
    else $error("dll not reset on stopped clocks");

  read_burst_c: cover property (rd_start ##[1:20] (rd_emit && rd_sel_beat == 2'h3));
  write_burst_c: cover property (wr_start ##[1:20] (wr_emit && wr_sel_beat == 2'h3));
  masked_write_c: cover property (wr_emit && BYTE_WRITE_MASK_N_IN != 4'h0);
  dll_lock_c: cover property ($rose(DLL_LOCKED_OUT));
endmodule

// file: sdb_pkg.sv
// constants for the separate-i/o ddr burst-of-four sram port
// assumes a single system clock that samples the k clocks as plain inputs
package sdb_pkg;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DATA_W = 36;
  localparam int BEATS = 4;
  localparam int BEAT_W = 2;
  localparam int ADDR_W = 10;
  localparam int CLK_PERIOD_PS = 50000;
  localparam int CLK_STOP_PS = 30000;
  localparam int CLK_STOP_CYC =
    (CLK_STOP_PS / CLK_PERIOD_PS) < 1 ? 1 : (CLK_STOP_PS / CLK_PERIOD_PS);
  localparam int LOCK_KCYC = 2048;
  localparam int LOCK_W = 12;
  localparam int IDLE_W = 4;
  localparam logic [LOCK_W-1:0] LOCK_RST = 12'h000;
  localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_LAST = 2'h3;
  localparam logic [DATA_W-1:0] DATA_IDLE = 36'h0_0000_0000;
endpackage

// file: sdb_edge_det.sv
// rising edge detector for a clock level sampled as a plain input
// assumes the level is synchronous to clk_in
`timescale 1ns/1ps
module sdb_edge_det (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // level and edge
  input wire logic level_in,
  output logic rise_out,
  output logic change_out
);
  logic prev_q;
  logic armed_q;

  // no edge is reported until one real sample of the level is held
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev_q <= 1'b0;
      armed_q <= 1'b0;
    end else begin
      prev_q <= level_in;
      armed_q <= 1'b1;
    end
  end

  assign rise_out = armed_q & level_in & ~prev_q;
  assign change_out = armed_q & (level_in ^ prev_q);
endmodule

// file: sdb_byte_ram.sv
// word array with one write port masked per 9-bit lane and one read port
// assumes one write per cycle; read is combinational
`timescale 1ns/1ps
module sdb_byte_ram #(
  parameter int AW = sdb_pkg::ADDR_W + sdb_pkg::BEAT_W,
  parameter int LANE_W = sdb_pkg::LANE_W,
  parameter int LANES = sdb_pkg::LANES
) (
  // clock
  input wire logic clk_in,
  // write port
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [LANE_W*LANES-1:0] wdata_in,
  input wire logic [LANES-1:0] wmask_n_in,
  // read port
  input wire logic [AW-1:0] raddr_in,
  output logic [LANE_W*LANES-1:0] rdata_out
);
  logic [LANE_W*LANES-1:0] mem [0:(1<<AW)-1];

  initial begin
    if (AW < 1 || LANES < 1 || LANE_W < 1) begin
      $error("sdb_byte_ram: bad geometry");
    end
  end

  always_ff @(posedge clk_in) begin
    for (int j = 0; j < LANES; j++) begin
      if (we_in && !wmask_n_in[j]) begin
        mem[waddr_in][j*LANE_W +: LANE_W] <= wdata_in[j*LANE_W +: LANE_W];
      end
    end
  end

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    lane_keep_a: assert property (@(posedge clk_in)
      (we_in && wmask_n_in[i]) |=>
        mem[$past(waddr_in)][i*LANE_W +: LANE_W] ==
          $past(mem[waddr_in][i*LANE_W +: LANE_W]))
      else $error("masked lane changed");
    lane_write_a: assert property (@(posedge clk_in)
      (we_in && !wmask_n_in[i]) |=>
        mem[$past(waddr_in)][i*LANE_W +: LANE_W] ==
          $past(wdata_in[i*LANE_W +: LANE_W]))
      else $error("unmasked lane not written");
  end

  assign rdata_out = mem[raddr_in];
endmodule

// file: sdb_ctrl_model.sv
// memory controller model driving the k clocks, commands and write beats
// assumes the bench calls its tasks and clk_in is the system clock
`timescale 1ns/1ps
module sdb_ctrl_model (
  // clock
  input wire logic clk_in,
  // input clocks
  output logic k_out,
  output logic k_bar_out,
  // command
  output logic [sdb_pkg::ADDR_W-1:0] addr_out,
  output logic rd_n_out,
  output logic wr_n_out,
  // write data
  output logic [sdb_pkg::DATA_W-1:0] data_out,
  output logic [sdb_pkg::LANES-1:0] mask_n_out,
  // dll control
  output logic dll_off_n_out
);
  logic hold_k;
  assign k_bar_out = ~k_out;
  initial begin
    k_out = 1'b0;
    hold_k = 1'b0;
    addr_out = '0;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    data_out = '0;
    mask_n_out = '0;
    dll_off_n_out = 1'b1;
  end
  // k runs at half the system clock; held only when a stop is asked for
  always @(posedge clk_in) begin
    #1;
    if (!hold_k) begin
      k_out = ~k_out;
    end
  end
  task automatic stop_k(input int n);
    @(posedge clk_in);
    hold_k = 1'b1;
    repeat (n) @(posedge clk_in);
    hold_k = 1'b0;
  endtask
  task automatic set_dll(input logic v);
    @(posedge clk_in);
    #1;
    dll_off_n_out = v;
  endtask
  // command valid for the next k rise
  task automatic cmd(input logic rn, input logic wn, input logic [sdb_pkg::ADDR_W-1:0] a);
    @(posedge clk_in);
    while (k_out) @(posedge clk_in);
    #1;
    rd_n_out = rn;
    wr_n_out = wn;
    addr_out = a;
  endtask
  // four beats with masks, plus an optional command at the next k rise
  task automatic beats(input logic [143:0] d, input logic [15:0] m, input logic rn,
                       input logic wn, input logic [sdb_pkg::ADDR_W-1:0] a);
    @(posedge clk_in);
    #1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    addr_out = ~addr_out;
    for (int b = 0; b < 4; b++) begin
      @(posedge clk_in);
      #1;
      data_out = d[36*b+:36];
      mask_n_out = m[4*b+:4];
      rd_n_out = (b == 0) ? rn : 1'b1;
      wr_n_out = (b == 0) ? wn : 1'b1;
      addr_out = (b == 0) ? a : ~addr_out;
    end
    @(posedge clk_in);
    #1;
    data_out = ~data_out;
  endtask
endmodule

// file: tb.sv
// self-checking bench: bursts, masks, refused commands and dll lock
// assumes the controller model drives every input but clock and reset
`timescale 1ns/1ps
module tb;
  localparam int LK = 8;
  localparam int AW = sdb_pkg::ADDR_W;
  logic clk, rst, k, kb, rdn, wrn, doff, oe, vld, ec, ecn, lck;
  logic [AW-1:0] addr;
  logic [sdb_pkg::DATA_W-1:0] wd, rdat;
  logic [sdb_pkg::LANES-1:0] wm;
  logic [35:0] exp_mem [0:4095];
  int miscompares = 0;
  int cmp_count = 0;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  sdb_ctrl_model CTL (.clk_in(clk), .k_out(k), .k_bar_out(kb), .addr_out(addr),
    .rd_n_out(rdn), .wr_n_out(wrn), .data_out(wd), .mask_n_out(wm), .dll_off_n_out(doff));
  sdb_sram_port #(.LOCK_KCYC(LK)) DUT (.CLK_IN(clk), .RESET_IN(rst), .K_IN(k),
    .K_BAR_IN(kb), .SYNC_ADDR_IN(addr), .READ_SEL_N_IN(rdn), .WRITE_SEL_N_IN(wrn),
    .WRITE_DATA_IN(wd), .BYTE_WRITE_MASK_N_IN(wm), .DLL_OFF_N_IN(doff),
    .READ_DATA_OUT(rdat), .READ_DATA_OE_OUT(oe), .OUT_DATA_VALID_OUT(vld),
    .ECHO_CLK_OUT(ec), .ECHO_CLK_N_OUT(ecn), .DLL_LOCKED_OUT(lck));
  task automatic conclude();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [143:0] pat(input logic [7:0] s);
    pat = {{s, 28'h123_4567}, {~s, 28'h89A_BCDE}, {s ^ 8'h5A, 28'h0F0_F0F0}, {s + 8'h01, 28'hC3C_3C3C}};
  endfunction
  task automatic upd(input logic [AW-1:0] a, input logic [143:0] d, input logic [15:0] m);
    for (int b = 0; b < 4; b++) begin
      for (int l = 0; l < 4; l++) begin
        if (!m[4*b+l]) begin
          exp_mem[{a, b[1:0]}][9*l+:9] = d[36*b+9*l+:9];
        end
      end
    end
  endtask
  // w edges after the command drive to the first read beat
  task automatic chk_read(input logic [AW-1:0] a, input int w);
    repeat (w) @(posedge clk);
    for (int b = 0; b < 4; b++) begin
      if (b > 0) begin
        @(posedge clk);
      end
      #2;
      chk(vld, 1'b1);
      chk(oe, 1'b1);
      chk(ec, !k);
      chk(ecn, k);
      chk(rdat, exp_mem[{a, b[1:0]}]);
    end
    @(posedge clk);
    #2;
    chk(vld, 1'b0);
    chk(oe, 1'b0);
    chk(rdat, sdb_pkg::DATA_IDLE);
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk);
      #2;
      chk(vld, 1'b0);
      chk(rdat, sdb_pkg::DATA_IDLE);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [143:0] d, input logic [15:0] m);
    CTL.cmd(1'b1, 1'b0, a);
    upd(a, d, m);
    CTL.beats(d, m, 1'b1, 1'b1, a);
  endtask
  task automatic rd(input logic [AW-1:0] a);
    CTL.cmd(1'b0, 1'b1, a);
    fork
      CTL.beats(pat(8'hEE), 16'h0000, 1'b1, 1'b1, a);
      chk_read(a, 5);
    join
  endtask
  task automatic dll_scn();
    #2;
    chk(lck, 1'b1);
    CTL.set_dll(1'b0);
    repeat (3) @(posedge clk);
    #2;
    chk(lck, 1'b0);
    CTL.set_dll(1'b1);
    repeat (2 * LK - 4) @(posedge clk);
    #2;
    chk(lck, 1'b0);
    repeat (8) @(posedge clk);
    #2;
    chk(lck, 1'b1);
    CTL.stop_k(3);
    @(posedge clk);
    #2;
    chk(lck, 1'b0);
    repeat (2 * LK + 4) @(posedge clk);
    #2;
    chk(lck, 1'b1);
  endtask
  initial begin
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (400) @(posedge clk);
    dll_scn();
    wr(10'h001, pat(8'h11), 16'h0000);
    rd(10'h001);
    wr(10'h001, pat(8'h22), 16'h5A0F);
    rd(10'h001);
    wr(10'h002, pat(8'h33), 16'h0000);
    CTL.cmd(1'b0, 1'b0, 10'h002);
    fork
      CTL.beats(pat(8'h44), 16'h0000, 1'b1, 1'b1, 10'h000);
      chk_read(10'h002, 5);
    join
    rd(10'h002);
    CTL.cmd(1'b1, 1'b1, 10'h001);
    fork
      CTL.beats(pat(8'h55), 16'h0000, 1'b1, 1'b1, 10'h000);
      quiet(12);
    join
    rd(10'h001);
    CTL.cmd(1'b0, 1'b1, 10'h001);
    fork
      CTL.beats(pat(8'h66), 16'hFFFF, 1'b0, 1'b1, 10'h002);
      chk_read(10'h001, 5);
    join
    CTL.cmd(1'b1, 1'b0, 10'h3FF);
    upd(10'h3FF, pat(8'h77), 16'h0000);
    CTL.beats(pat(8'h77), 16'h0000, 1'b1, 1'b0, 10'h002);
    rd(10'h002);
    rd(10'h3FF);
    CTL.cmd(1'b1, 1'b0, 10'h004);
    upd(10'h004, pat(8'h88), 16'h0000);
    fork
      CTL.beats(pat(8'h88), 16'h0000, 1'b0, 1'b1, 10'h001);
      chk_read(10'h001, 7);
    join
    rd(10'h004);
    conclude();
  end
  // whole run needs about 600 cycles; allow far more
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule
